// ==== verilog/gigc_pkg.sv ====
// package: constants and types for the global interrupt gateway core
package gigc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int N_SRC = 7;
  localparam int N_TGT = 2;
  localparam int PRIO_W = 3;
  localparam int ID_W = 3;
  localparam int CNT_W = 2;
  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 10'h000;
  localparam logic [ADDR_W-1:0] PRIO_STRIDE = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 10'h040;
  localparam logic [ADDR_W-1:0] OFS_SRC_MODE = 10'h044;
  localparam logic [ADDR_W-1:0] OFS_MSG = 10'h048;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_BASE = 10'h080;
  localparam logic [ADDR_W-1:0] ENABLE_STRIDE = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_THRESH_BASE = 10'h100;
  localparam logic [ADDR_W-1:0] OFS_CLAIM_BASE = 10'h104;
  localparam logic [ADDR_W-1:0] TGT_STRIDE = 10'h010;

  // ----------------------------------------------------------------
  // legalized_write_field masks and reset values
  // ----------------------------------------------------------------
  // source 7 is hardwired to priority 1
  localparam logic [N_SRC:1][PRIO_W-1:0] PRIO_WRITABLE =
    {3'h0, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
  localparam logic [N_SRC:1][PRIO_W-1:0] PRIO_FIXED_ONE =
    {3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  // bit 0 is the empty id; target 1 cannot see source 7
  localparam logic [N_TGT-1:0][N_SRC:0] EN_WRITABLE = {8'h7E, 8'hFE};
  localparam logic [N_TGT-1:0][N_SRC:0] EN_FIXED_ONE = {8'h00, 8'h00};
  localparam logic [PRIO_W-1:0] THRESH_WRITABLE = 3'h7;
  localparam logic [PRIO_W-1:0] THRESH_RST = 3'h0;
  localparam logic [N_SRC:1] SRC_MODE_RST = 7'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 2'h3;

  // target privilege routing: target 0 machine, target 1 supervisor
  localparam logic [N_TGT-1:0] TGT_TO_M = 2'h1;
  localparam logic [N_TGT-1:0] TGT_TO_S = 2'h2;
  localparam logic [N_TGT-1:0] TGT_TO_U = 2'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } gigc_bus_e;

  typedef struct packed {
    logic busy;
    logic [CNT_W-1:0] cnt;
  } gigc_gw_s;

  localparam gigc_gw_s GW_IDLE = '{busy: 1'b0, cnt: 2'h0};

endpackage

// ==== verilog/gigc_core.sv ====
// design: global interrupt gateway core with an avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01 - each source has at most one request outstanding, held in its pending bit
// RULE_02 - a gateway forwards again only after completion of its previous request
// RULE_03 - level source: first assertion makes a request, then none until completion
// RULE_04 - completion while level still asserted forwards a fresh request at once
// RULE_05 - forwarded requests are never withdrawn; pending stays until claimed
// RULE_06 - edge source: first rising edge becomes a request
// RULE_07 - edges while busy are counted; counter decrements on acceptance
// RULE_08 - message write selects one gateway and acts as an edge event
// RULE_09 - source ids start at one; id zero means no interrupt
// RULE_10 - equal priority ties go to the smaller id
// RULE_11 - priority zero never interrupts; larger values are more urgent
// RULE_12 - priority registers legalize writes; all writable bit combinations valid
// RULE_13 - software probes priority bits by writing zeros then ones and reading back
// RULE_14 - one enable bit per source per target; disabled sources never notify
// RULE_15 - enable bits legalize writes and may be fixed at zero or one
// RULE_16 - notify only when priority is strictly above the target threshold
// RULE_17 - thresholds legalize writes; zero and maximum priority are accepted
// RULE_18 - one external pending bit per target tracks core state
// RULE_19 - external pending goes to machine, supervisor or user input by privilege
// RULE_20 - an active source notifies every target that enables it
// RULE_21 - every change of external pending reaches the target
// RULE_22 - a target claim may find nothing after another target claimed it
// RULE_23 - claim picks best eligible source, clears its pending, returns id or zero
// RULE_24 - a gateway request is accepted only while pending is clear
// RULE_25 - reset clears pending bits and counters and idles all gateways
module gigc_core (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [gigc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [gigc_pkg::N_SRC:1] irq_src,
  output logic [gigc_pkg::N_TGT-1:0] target_external_pending,
  output logic machine_ext_pending,
  output logic supervisor_ext_pending,
  output logic user_ext_pending
);

  localparam int NS = gigc_pkg::N_SRC;
  localparam int NT = gigc_pkg::N_TGT;
  localparam int PW = gigc_pkg::PRIO_W;
  localparam int IW = gigc_pkg::ID_W;
  localparam int AW = gigc_pkg::ADDR_W;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] legalize(input logic [7:0] wd, input logic [7:0] wr,
                                          input logic [7:0] fo);
    return (wd & wr) | (fo & ~wr);
  endfunction

  function automatic logic [AW-1:0] slot(input logic [AW-1:0] base,
                                         input logic [AW-1:0] stride, input int idx);
    logic [AW-1:0] k;
    k = idx[AW-1:0];
    return base + k * stride;
  endfunction

  // scanning down with >= lets the smaller id win a tie; no threshold here, so masked targets poll
  function automatic logic [IW-1:0] pick_best(input logic [NS:1] cand,
                                              input logic [NS:1][PW-1:0] pr);
    logic [IW-1:0] id;
    logic [PW-1:0] top;
    id = '0;
    top = '0;
    for (int i = NS; i >= 1; i--) begin
      if (cand[i] && pr[i] != '0 && pr[i] >= top) begin // RULE_11
        id = i[IW-1:0];
        top = pr[i];
      end
    end
    return id;
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [NS:1] sync1, sync2, sync3, lvl, lvl_d, next_lvl, rise;
  gigc_pkg::gigc_bus_e state, next_state;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic [NS:1][PW-1:0] prio, next_prio;
  logic [NT-1:0][NS:0] en, next_en;
  logic [NT-1:0][PW-1:0] thr, next_thr;
  logic [NS:1] src_edge, next_mode;
  logic [NS:1] msg_evt, cmpl_vec, claim_clr;
  logic claim_rd;
  logic [IW-1:0] claim_id;
  logic [NS:1] pend, next_pend, fwd;
  gigc_pkg::gigc_gw_s [NS:1] gw, next_gw;
  logic [NT-1:0][NS:1] elig;
  logic [NT-1:0][IW-1:0] best;
  logic [NT-1:0] next_tep;
  logic next_m, next_s, next_u;

  // ----------------------------------------------------------------
  // source input synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    // a level change is taken only once the last two stages agree
    next_lvl = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & lvl);
    rise = lvl & ~lvl_d;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      lvl <= '0;
      lvl_d <= '0;
    end else begin
      sync1 <= irq_src;
      sync2 <= sync1;
      sync3 <= sync2;
      lvl <= next_lvl;
      lvl_d <= lvl;
    end
  end

  // ----------------------------------------------------------------
  // avalon slave and register file
  // ----------------------------------------------------------------
  always_comb begin
    logic rd;
    logic wr;
    logic [7:0] legal;
    logic [IW-1:0] id;
    rd = 1'b0;
    wr = 1'b0;
    legal = '0;
    id = avs_writedata[IW-1:0];
    next_state = state;
    next_waitrequest = avs_waitrequest;
    next_readdata = avs_readdata;
    next_prio = prio;
    next_en = en;
    next_thr = thr;
    next_mode = src_edge;
    msg_evt = '0;
    cmpl_vec = '0;
    claim_clr = '0;
    claim_rd = 1'b0;
    claim_id = '0;
    // every access is taken on its first edge and answered one cycle later
    case (state)
      gigc_pkg::BUS_IDLE: begin
        if (avs_read || avs_write) begin
          rd = avs_read;
          wr = avs_write && avs_byteenable[0];
          next_state = gigc_pkg::BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = '0;
        end
      end
      gigc_pkg::BUS_ANSWER: begin
        next_state = gigc_pkg::BUS_IDLE;
        next_waitrequest = 1'b1;
      end
      default: begin
        next_state = gigc_pkg::BUS_IDLE;
        next_waitrequest = 1'b1;
      end
    endcase
    for (int i = 1; i <= NS; i++) begin
      if (avs_address == slot(gigc_pkg::OFS_PRIO_BASE, gigc_pkg::PRIO_STRIDE, i)) begin
        if (rd) begin
          next_readdata = 32'(prio[i]);
        end
        if (wr) begin
          legal = legalize(avs_writedata[7:0], 8'(gigc_pkg::PRIO_WRITABLE[i]),
                           8'(gigc_pkg::PRIO_FIXED_ONE[i])); // RULE_12
          next_prio[i] = legal[PW-1:0];
        end
      end
    end
    if (avs_address == gigc_pkg::OFS_PENDING && rd) begin
      next_readdata = 32'({pend, 1'b0});
    end
    if (avs_address == gigc_pkg::OFS_SRC_MODE) begin
      if (rd) begin
        next_readdata = 32'({src_edge, 1'b0});
      end
      if (wr) begin
        next_mode = avs_writedata[NS:1];
      end
    end
    if (avs_address == gigc_pkg::OFS_MSG && wr && id != '0) begin
      msg_evt[id] = 1'b1; // RULE_08
    end
    for (int t = 0; t < NT; t++) begin
      if (avs_address == slot(gigc_pkg::OFS_ENABLE_BASE, gigc_pkg::ENABLE_STRIDE, t)) begin
        if (rd) begin
          next_readdata = 32'(en[t]);
        end
        if (wr) begin
          next_en[t] = legalize(avs_writedata[7:0], gigc_pkg::EN_WRITABLE[t],
                                gigc_pkg::EN_FIXED_ONE[t]); // RULE_15
        end
      end
      if (avs_address == slot(gigc_pkg::OFS_THRESH_BASE, gigc_pkg::TGT_STRIDE, t)) begin
        if (rd) begin
          next_readdata = 32'(thr[t]);
        end
        if (wr) begin
          legal = legalize(avs_writedata[7:0], 8'(gigc_pkg::THRESH_WRITABLE), 8'h00);
          next_thr[t] = legal[PW-1:0]; // RULE_17
        end
      end
      if (avs_address == slot(gigc_pkg::OFS_CLAIM_BASE, gigc_pkg::TGT_STRIDE, t)) begin
        if (rd) begin
          // claim and clear happen on the same edge, so no other target can win it
          next_readdata = 32'(best[t]); // RULE_23 RULE_22
          claim_rd = 1'b1;
          claim_id = best[t];
          if (best[t] != '0) begin
            claim_clr[best[t]] = 1'b1; // RULE_09
          end
        end
        if (wr && id != '0) begin
          cmpl_vec[id] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= gigc_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
      prio <= gigc_pkg::PRIO_FIXED_ONE;
      en <= gigc_pkg::EN_FIXED_ONE;
      thr <= {NT{gigc_pkg::THRESH_RST}};
      src_edge <= gigc_pkg::SRC_MODE_RST;
    end else begin
      state <= next_state;
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
      prio <= next_prio;
      en <= next_en;
      thr <= next_thr;
      src_edge <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // gateways and pending bits
  // ----------------------------------------------------------------
  always_comb begin
    logic want;
    logic inc;
    logic dec;
    want = 1'b0;
    inc = 1'b0;
    dec = 1'b0;
    next_gw = gw;
    next_pend = pend;
    for (int i = 1; i <= NS; i++) begin
      // a level source asks while high; counted edges and messages ask in any mode
      want = (gw[i].cnt != '0) || (!src_edge[i] && lvl[i]); // RULE_03 RULE_06
      fwd[i] = !gw[i].busy && want && !pend[i]; // RULE_02 RULE_24
      inc = (src_edge[i] && rise[i]) || msg_evt[i]; // RULE_07 RULE_08
      dec = fwd[i] && gw[i].cnt != '0; // RULE_07
      if (inc && !dec && gw[i].cnt != gigc_pkg::CNT_MAX) begin
        next_gw[i].cnt = gw[i].cnt + 2'h1;
      end else if (dec && !inc) begin
        next_gw[i].cnt = gw[i].cnt - 2'h1;
      end
      if (fwd[i]) begin
        next_gw[i].busy = 1'b1;
      end else if (cmpl_vec[i]) begin
        next_gw[i].busy = 1'b0; // RULE_04
      end
      // only a claim clears pending; a falling level leaves it set
      if (fwd[i]) begin
        next_pend[i] = 1'b1; // RULE_01
      end else if (claim_clr[i]) begin
        next_pend[i] = 1'b0; // RULE_05
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend <= '0; // RULE_25
      for (int i = 1; i <= NS; i++) begin
        gw[i] <= gigc_pkg::GW_IDLE;
      end
    end else begin
      pend <= next_pend;
      gw <= next_gw;
    end
  end

  // ----------------------------------------------------------------
  // target selection and notification
  // ----------------------------------------------------------------
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      for (int i = 1; i <= NS; i++) begin
        // priority zero can never exceed a threshold
        elig[t][i] = pend[i] && en[t][i] && (prio[i] > thr[t]); // RULE_11 RULE_14 RULE_16
      end
      best[t] = pick_best(pend & en[t][NS:1], prio); // RULE_10 RULE_14
      next_tep[t] = |elig[t]; // RULE_18 RULE_20
    end
    next_m = |(next_tep & gigc_pkg::TGT_TO_M); // RULE_19
    next_s = |(next_tep & gigc_pkg::TGT_TO_S);
    next_u = |(next_tep & gigc_pkg::TGT_TO_U);
  end

  // notification wires are refreshed every cycle, so no change is dropped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      target_external_pending <= '0;
      machine_ext_pending <= 1'b0;
      supervisor_ext_pending <= 1'b0;
      user_ext_pending <= 1'b0;
    end else begin
      target_external_pending <= next_tep; // RULE_21
      machine_ext_pending <= next_m;
      supervisor_ext_pending <= next_s;
      user_ext_pending <= next_u;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking chk_cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [NS:1] busy_v;
  logic [NS:0] pend_z;
  always_comb begin
    for (int i = 1; i <= NS; i++) begin
      busy_v[i] = gw[i].busy;
    end
    pend_z = {pend, 1'b0};
  end

  chk_accept_clear: // RULE_24
    assert property ((pend & ~$past(pend) & ~$past(fwd)) == '0)
      else $error("pending bit set without an accepted request");
  chk_single_request: // RULE_01
    assert property ((fwd & pend) == '0)
      else $error("request forwarded onto a set pending bit");
  chk_busy_release: // RULE_02
    assert property ((~busy_v & $past(busy_v) & ~$past(cmpl_vec)) == '0)
      else $error("gateway released without completion");
  chk_no_withdraw: // RULE_05
    assert property ((~pend & $past(pend) & ~$past(claim_clr)) == '0)
      else $error("pending bit cleared without a claim");
  chk_level_refire: // RULE_04
    assert property ((cmpl_vec[1] && busy_v[1] && !src_edge[1] && lvl[1] && !pend[1])
                     |=> (fwd[1] || !lvl[1] || src_edge[1]))
      else $error("level still high after completion but no new request");
  chk_edge_count: // RULE_07
    assert property ((src_edge[1] && rise[1] && busy_v[1] && !fwd[1]
                      && gw[1].cnt != gigc_pkg::CNT_MAX)
                     |=> gw[1].cnt == $past(gw[1].cnt) + 2'h1)
      else $error("edge during service not counted");
  chk_claim_result: // RULE_23
    assert property (claim_rd |=> (avs_readdata == 32'($past(claim_id)))
                     && !pend_z[$past(claim_id)] && !avs_waitrequest)
      else $error("claim answer or pending clear wrong");
  chk_empty_claim: // RULE_09
    assert property ((claim_rd && claim_id == '0) |-> claim_clr == '0 ##1 avs_readdata == '0)
      else $error("empty claim must return zero and clear nothing");
  chk_notify_tracks: // RULE_18
    assert property (target_external_pending[0] == $past(|elig[0]))
      else $error("target 0 notification out of step with core");
  chk_multicast: // RULE_20
    assert property ((elig[0][1] && elig[1][1]) |=> &target_external_pending)
      else $error("shared source did not notify every target");
  chk_bus_answer:
    assert property (((avs_read || avs_write) && state == gigc_pkg::BUS_IDLE)
                     |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer not one cycle after capture");

  cov_claim_hit: cover property (claim_rd && claim_id != '0);
  cov_completion: cover property (|(cmpl_vec & busy_v));
  cov_level_refire: cover property (cmpl_vec[1] && lvl[1] ##1 fwd[1]);
  cov_message: cover property (|msg_evt);
  cov_multicast: cover property (&target_external_pending);

endmodule
`default_nettype wire

// ==== verif/gigc_hart_model.sv ====
// partner model: hart contexts that reach the core as an avalon-mm master
`timescale 1ns/1ps
`default_nettype none
module gigc_hart_model (
  input wire logic ref_clk,
  output logic [gigc_pkg::ADDR_W-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released lines flip so that a slave relying on stale values is caught
  task automatic access(input int a, input logic wr, input logic [31:0] d,
                        output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a[gigc_pkg::ADDR_W-1:0];
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~avs_address;
    avs_writedata <= ~avs_writedata;
  endtask

  // an empty answer is accepted: another context may have won the race
  task automatic claim(input int t, output logic [31:0] id);
    access(gigc_pkg::OFS_CLAIM_BASE + gigc_pkg::TGT_STRIDE * t, 1'b0, 32'h0, id);
  endtask

  task automatic probe(input int a, output logic [31:0] lo, output logic [31:0] hi);
    access(a, 1'b1, 32'h0, lo);
    access(a, 1'b0, 32'h0, lo);
    access(a, 1'b1, 32'hFFFFFFFF, hi);
    access(a, 1'b0, 32'h0, hi);
  endtask
endmodule
`default_nettype wire

// ==== verif/gigc_core_tb_top.sv ====
// testbench: gigc_core against a behavioural model of gateways and core
`timescale 1ns/1ps
`default_nettype none
module gigc_core_tb_top;
  logic ref_clk;
  logic rst;
  logic [gigc_pkg::N_SRC:1] irq_src;
  logic [gigc_pkg::ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] tep;
  logic m_ep;
  logic s_ep;
  logic u_ep;
  int failures;
  int tests_run;
  int cyc;
  int prio[8];
  int cnt[8];
  int thr[2];
  logic [7:0] en[2];
  bit pend[8];
  bit busy[8];
  bit lvl[8];
  bit edge_on;

  gigc_core u_gigc_core (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq_src(irq_src), .target_external_pending(tep),
    .machine_ext_pending(m_ep), .supervisor_ext_pending(s_ep), .user_ext_pending(u_ep));
  gigc_hart_model u_gigc_hart_model (.ref_clk(ref_clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // model
  // ----------------------------------------------------------------
  function automatic int best(int t);
    int b;
    b = 0;
    for (int n = 7; n >= 1; n--)
      if (pend[n] && en[t][n] && prio[n] > 0 && (b == 0 || prio[n] >= prio[b])) b = n;
    return b;
  endfunction

  function automatic logic [1:0] notify();
    logic [1:0] e;
    e = 2'h0;
    for (int t = 0; t < 2; t++)
      for (int n = 1; n <= 7; n++)
        if (pend[n] && en[t][n] && prio[n] > thr[t]) e[t] = 1'b1;
    return e;
  endfunction

  task automatic forward();
    for (int n = 1; n <= 7; n++)
      if (!busy[n] && (cnt[n] > 0 || (!edge_on && lvl[n]))) begin
        if (cnt[n] > 0) cnt[n]--;
        busy[n] = 1;
        pend[n] = 1;
      end
  endtask

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wr(input int a, input logic [31:0] d);
    logic [31:0] q;
    u_gigc_hart_model.access(a, 1'b1, d, q);
  endtask

  task automatic rd(input int a, output logic [31:0] q);
    u_gigc_hart_model.access(a, 1'b0, 32'h0, q);
  endtask

  task automatic set_prio(input int n, input int p);
    wr(gigc_pkg::OFS_PRIO_BASE + gigc_pkg::PRIO_STRIDE * n, p);
    prio[n] = (p & gigc_pkg::PRIO_WRITABLE[n]) | gigc_pkg::PRIO_FIXED_ONE[n];
  endtask

  task automatic set_en(input int t, input int e);
    wr(gigc_pkg::OFS_ENABLE_BASE + gigc_pkg::ENABLE_STRIDE * t, e);
    en[t] = (e[7:0] & gigc_pkg::EN_WRITABLE[t]) | gigc_pkg::EN_FIXED_ONE[t];
  endtask

  task automatic set_thr(input int t, input int v);
    wr(gigc_pkg::OFS_THRESH_BASE + gigc_pkg::TGT_STRIDE * t, v);
    thr[t] = v & gigc_pkg::THRESH_WRITABLE;
  endtask

  task automatic set_pins(input logic [7:1] v);
    @(posedge ref_clk);
    irq_src <= v;
    for (int n = 1; n <= 7; n++) begin
      if (v[n] && !lvl[n] && edge_on && cnt[n] < gigc_pkg::CNT_MAX) cnt[n]++;
      lvl[n] = v[n];
    end
    repeat (10) @(posedge ref_clk);
    forward();
  endtask

  task automatic check_state();
    logic [31:0] q;
    logic [31:0] got;
    logic [1:0] e;
    q = 32'h0;
    for (int n = 1; n <= 7; n++) q[n] = pend[n];
    e = notify();
    cmp("notify", {30'h0, e}, {30'h0, tep});
    cmp("privilege lines", {29'h0, |(e & gigc_pkg::TGT_TO_U), |(e & gigc_pkg::TGT_TO_S),
      |(e & gigc_pkg::TGT_TO_M)}, {29'h0, u_ep, s_ep, m_ep});
    rd(gigc_pkg::OFS_PENDING, got);
    cmp("pending", {24'h0, q[7:0]}, got);
  endtask

  task automatic claim(input int t, output int id);
    logic [31:0] q;
    id = best(t);
    u_gigc_hart_model.claim(t, q);
    cmp("claim id", id, q);
    pend[id] = 0;
    repeat (3) @(posedge ref_clk);
    cmp("notify after claim", {30'h0, notify()}, {30'h0, tep});
  endtask

  task automatic complete(input int id);
    wr(gigc_pkg::OFS_CLAIM_BASE, id);
    busy[id] = 0;
    repeat (6) @(posedge ref_clk);
    forward();
  endtask

  task automatic drain();
    int id;
    set_pins(7'h00);
    set_en(0, 32'hFF);
    set_thr(0, 0);
    for (int n = 1; n <= 7; n++) set_prio(n, 7);
    repeat (16) begin
      claim(0, id);
      complete(id);
    end
    check_state();
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] lo;
    logic [31:0] hi;
    int id;
    rst = 1'b1;
    irq_src = '0;
    en[0] = 8'h00;
    en[1] = 8'h00;
    for (int n = 1; n <= 7; n++) prio[n] = gigc_pkg::PRIO_FIXED_ONE[n];
    void'($urandom(32'hEC65));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(gigc_pkg::OFS_PENDING, lo);
    cmp("pending after reset", 32'h0, lo);
    rd(32'h3FC, lo);
    cmp("unmapped read", 32'h0, lo);
    for (int n = 1; n <= 7; n++) begin
      u_gigc_hart_model.probe(gigc_pkg::OFS_PRIO_BASE + gigc_pkg::PRIO_STRIDE * n, lo, hi);
      cmp("prio ones", 32'(gigc_pkg::PRIO_FIXED_ONE[n]), lo);
      prio[n] = gigc_pkg::PRIO_WRITABLE[n] | gigc_pkg::PRIO_FIXED_ONE[n];
      cmp("prio bits", prio[n], hi);
    end
    for (int t = 0; t < 2; t++) begin
      set_en(t, 32'hFF);
      rd(gigc_pkg::OFS_ENABLE_BASE + gigc_pkg::ENABLE_STRIDE * t, lo);
      cmp("enable bits", {24'h0, en[t]}, lo);
      set_thr(t, 7);
      rd(gigc_pkg::OFS_THRESH_BASE + gigc_pkg::TGT_STRIDE * t, lo);
      cmp("threshold max", 32'h7, lo);
    end
    $display("test registers done");
    for (int r = 0; r < 8; r++) begin
      for (int n = 1; n <= 7; n++) set_prio(n, $urandom_range(7, 0));
      for (int t = 0; t < 2; t++) begin
        set_en(t, $urandom_range(255, 0));
        set_thr(t, $urandom_range(4, 0));
      end
      set_pins(7'($urandom_range(127, 0)));
      check_state();
      // target 0 masks everything and polls by claims; target 1 keeps its random threshold
      set_thr(0, 7);
      for (int k = 0; k < 4; k++) claim(k % 2, id);
      set_pins(7'($urandom_range(127, 0)));
      check_state();
      for (int n = 1; n <= 7; n++) if (busy[n] && !pend[n]) complete(n);
      check_state();
      drain();
    end
    $display("test level sources done");
    edge_on = 1;
    wr(gigc_pkg::OFS_SRC_MODE, 32'hFE);
    for (int n = 1; n <= 6; n++) set_prio(n, 3);
    repeat (3) begin
      set_pins(7'h02);
      set_pins(7'h00);
    end
    for (int n = 0; n <= 7; n++) begin
      wr(gigc_pkg::OFS_MSG, n);
      if (n > 0 && cnt[n] < gigc_pkg::CNT_MAX) cnt[n]++;
    end
    repeat (6) @(posedge ref_clk);
    forward();
    check_state();
    drain();
    $display("test edge sources and messages done");
    end_sim();
  end
endmodule
`default_nettype wire
